// ### dv/t16bac_core_tb.sv
`timescale 1ns/1ps
module t16bac_core_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, b;
   logic [31:0] pwdata, prdata;
   logic ext_count_pin, capture_input_pin, comparator_out;
   logic wave_out_a, wave_out_b, at_bottom, at_max, err;
   logic [3:0] timer_irq_req;
   logic [15:0] w, c1, c2;
   int failures, check_count, n;

   t16bac_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count_pin(ext_count_pin), .capture_input_pin(capture_input_pin),
      .comparator_out(comparator_out), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
      .timer_irq_req(timer_irq_req), .at_bottom(at_bottom), .at_max(at_max));
   t16bac_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 50 MHz
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("failures %0d, checks %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   task automatic t_reset;
      check(at_bottom, 1'b1, "bottom after reset");
      check(timer_irq_req, 4'h0, "irq after reset");
      cpu.rd8(t16bac_pkg::ADR_POWER, b);
      check(b, 8'h01, "power bit reset");
   endtask : t_reset

   // control registers are plain bytes; tick source stays stopped
   task automatic t_ctrl;
      cpu.wr8(t16bac_pkg::ADR_CTRL_A, 8'h33);
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'hC8);
      cpu.rd8(t16bac_pkg::ADR_CTRL_A, b);
      check(b, 8'h33, "ctrl a");
      cpu.rd8(t16bac_pkg::ADR_CTRL_B, b);
      check(b, 8'hC8, "ctrl b");
      cpu.wr8(t16bac_pkg::ADR_CTRL_A, 8'h00);
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h00);
   endtask : t_ctrl

   // staging byte shared by all words; lone high write commits nothing
   task automatic t_stage;
      cpu.wr8(t16bac_pkg::ADR_CNT_HI, 8'h12);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, w);
      check(w, 16'h0000, "lone high write");
      cpu.wr16(t16bac_pkg::ADR_CNT_LO, 16'h1234);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, w);
      check(w, 16'h1234, "counter word");
      cpu.wr8(t16bac_pkg::ADR_CMPA_HI, 8'h56);
      cpu.wr8(t16bac_pkg::ADR_CMPA_LO, 8'h78);
      cpu.wr8(t16bac_pkg::ADR_CMPB_LO, 8'h9A);
      cpu.rd8(t16bac_pkg::ADR_CNT_LO, b);
      cpu.rd16(t16bac_pkg::ADR_CMPB_LO, w);
      check(w, 16'h569A, "reused stage");
      cpu.rd8(t16bac_pkg::ADR_CMPA_HI, b);
      check(b, 8'h56, "compare high direct");
      cpu.rd8(t16bac_pkg::ADR_CNT_HI, b);
      check(b, 8'h12, "stage kept");
      cpu.xfer(1'b0, 8'hFC, 8'h00, b, err);
      check({err, b}, 9'h100, "unmapped");
   endtask : t_stage

   // overflow then match A, max and bottom, masking and clearing
   task automatic t_run;
      cpu.wr8(t16bac_pkg::ADR_POWER, 8'h00);
      cpu.wr8(t16bac_pkg::ADR_MASK, 8'h0F);
      cpu.wr8(t16bac_pkg::ADR_CTRL_A, 8'h30);
      cpu.wr16(t16bac_pkg::ADR_CMPA_LO, 16'h0004);
      cpu.wr16(t16bac_pkg::ADR_CMPB_LO, 16'h0006);
      cpu.wr16(t16bac_pkg::ADR_CNT_LO, 16'hFFF8);
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h41);
      for (n = 0; n < 40 && at_max !== 1'b1; n++) @(posedge pclk);
      check(at_max, 1'b1, "max reached");
      for (n = 0; n < 4 && at_bottom !== 1'b1; n++) @(posedge pclk);
      check({at_max, at_bottom}, 2'b01, "bottom follows max");
      repeat (20) @(posedge pclk);
      cpu.rd8(t16bac_pkg::ADR_FLAGS, b);
      check(b & 8'h07, 8'h07, "overflow and matches");
      check(timer_irq_req[2:0], 3'b111, "requests");
      check({wave_out_a, wave_out_b}, 2'b11, "waves toggled on match");
      cpu.wr8(t16bac_pkg::ADR_MASK, 8'h0C);
      // the request register follows the mask one cycle after the write lands
      @(posedge pclk);
      check(timer_irq_req[1:0], 2'b00, "masked");
      cpu.wr8(t16bac_pkg::ADR_FLAGS, 8'h03);
      cpu.rd8(t16bac_pkg::ADR_FLAGS, b);
      check(b & 8'h03, 8'h00, "cleared");
   endtask : t_run

   // a rising capture edge stores a count between two counter reads
   task automatic t_capture;
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, c1);
      capture_input_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, c2);
      cpu.rd16(t16bac_pkg::ADR_CAP_LO, w);
      check(w > c1 && w < c2, 1'b1, "capture in range");
      cpu.rd8(t16bac_pkg::ADR_FLAGS, b);
      check(b[3], 1'b1, "capture flag");
      check(timer_irq_req[3], 1'b1, "capture request");
   endtask : t_capture

   // no source holds the count; pin rising edges each add one
   task automatic t_source;
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h40);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, c1);
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h47);
      repeat (3) begin
         ext_count_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_count_pin <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, c2);
      check(16'(c2 - c1), 16'h0003, "pin edges counted");
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h40);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, c2);
      cpu.rd16(t16bac_pkg::ADR_CNT_LO, w);
      check(w, c2, "stopped");
   endtask : t_source

   // 8-bit pwm wraps at 0x00FF and never reaches max
   task automatic t_top;
      cpu.wr8(t16bac_pkg::ADR_CTRL_A, 8'h01);
      cpu.wr16(t16bac_pkg::ADR_CNT_LO, 16'h00F8);
      cpu.wr8(t16bac_pkg::ADR_CTRL_B, 8'h41);
      for (n = 0; n < 40 && at_bottom !== 1'b1; n++) @(posedge pclk);
      check({at_max, at_bottom}, 2'b01, "fixed top wrap");
   endtask : t_top

   initial begin
      failures = 0;
      check_count = 0;
      presetn = 1'b0;
      ext_count_pin = 1'b0;
      capture_input_pin = 1'b0;
      comparator_out = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ctrl();
      t_stage();
      t_run();
      t_capture();
      t_source();
      t_top();
      print_verdict();
   end

   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      print_verdict();
   end
endmodule : t16bac_core_tb

// ### dv/t16bac_cpu_model.sv
`timescale 1ns/1ps
// processor-side byte master; speaks apb to the timer registers
module t16bac_cpu_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // one transfer, entered just after a rising edge; waits for pready as long as it
   // takes (the bench watchdog ends a hang), and an idle cycle follows the release
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr8(input logic [7:0] adr, input logic [7:0] wd);
      logic [7:0] rd;
      logic err;
      xfer(1'b1, adr, wd, rd, err);
   endtask : wr8

   task automatic rd8(input logic [7:0] adr, output logic [7:0] rd);
      logic err;
      xfer(1'b0, adr, 8'h00, rd, err);
   endtask : rd8

   // high byte first, then the committing low byte, nothing in between
   task automatic wr16(input logic [7:0] lo_adr, input logic [15:0] v);
      wr8(8'(lo_adr + 8'h04), v[15:8]);
      wr8(lo_adr, v[7:0]);
   endtask : wr16

   // low byte first so the high byte comes from the staged copy
   task automatic rd16(input logic [7:0] lo_adr, output logic [15:0] v);
      rd8(lo_adr, v[7:0]);
      rd8(8'(lo_adr + 8'h04), v[15:8]);
   endtask : rd16
endmodule : t16bac_cpu_model

// ### src/t16bac_capture_in.sv
`timescale 1ns/1ps
module t16bac_capture_in #(
   parameter int FILT_LEN = t16bac_pkg::FILTER_LEN
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic use_comp,
   input wire logic rising,
   input wire logic filter_en,
   input wire logic capture_input_pin,
   input wire logic comparator_out,
   output logic event_pulse
);
   logic raw_ff;
   logic [FILT_LEN-1:0] hist_ff;
   logic filt_ff;
   logic lvl_prev_ff;
   logic lvl;

   // filter accepts a new level only after FILT_LEN equal samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_ff <= 1'b0;
         hist_ff <= '0;
         filt_ff <= 1'b0;
         lvl_prev_ff <= 1'b0;
      end else begin
         raw_ff <= use_comp ? comparator_out : capture_input_pin;
         hist_ff <= {hist_ff[FILT_LEN-2:0], raw_ff};
         filt_ff <= (&hist_ff) | (filt_ff & (|hist_ff));
         lvl_prev_ff <= lvl;
      end
   end

   // with filter_en set, the filter adds FILT_LEN+1 cycles of latency to a capture
   assign lvl = filter_en ? filt_ff : raw_ff;
   assign event_pulse = run & (rising ? (lvl & ~lvl_prev_ff) : (~lvl & lvl_prev_ff));
endmodule : t16bac_capture_in

// ### src/t16bac_core.sv
`timescale 1ns/1ps
// Behaviour
// - counter, compares, capture are 16 bits, byte-accessed
// - one high-byte staging register shared by all
// - low-byte write commits staged high plus low
// - counter and capture low-byte reads copy high byte into staging
// - compare reads bypass the staging register entirely
// - both control registers plain 8-bit read/write
// - four interrupt sources, each with its flag
// - flags readable, each gated by a mask bit
// - prescaler or pin tick; stopped without source
// - compares double buffered, compared, drive waveforms
// - compare match sets that channel's match flag
// - selected edge event stores counter into capture, except while capture sets top
// - bottom condition when counter equals zero
// - max condition when counter is all ones
// - top is fixed value, compare A or capture
// - compare A as pwm top: no A output, buffered
// - timer runs only while power-off bit clear
// - counter high-byte access goes to staging register
module t16bac_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_pin,
   input wire logic capture_input_pin,
   input wire logic comparator_out,
   output logic wave_out_a,
   output logic wave_out_b,
   output logic [3:0] timer_irq_req,
   output logic at_bottom,
   output logic at_max
);
   logic [7:0] ctrl_a_ff, ctrl_b_ff, stage_ff;
   logic [15:0] count_ff, cmp_a_buf_ff, cmp_b_buf_ff, cmp_a_act_ff, cmp_b_act_ff, capture_ff;
   logic [3:0] flags_ff, mask_ff, irq_ff;
   logic power_off_ff, block_ff, wave_a_ff, wave_b_ff, bottom_ff, max_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;

   // apb phases: read side effects at the first access edge, writes when pready is seen
   logic acc_prep, wr_do, rd_do;
   logic [7:0] wbyte;
   assign acc_prep = psel & penable & ~pready_ff;
   assign wr_do = psel & penable & pready_ff & pwrite;
   assign rd_do = acc_prep & ~pwrite;
   assign wbyte = pwdata[7:0];

   // address decode
   logic hit_ca, hit_cb, hit_cnt_lo, hit_cnt_hi, hit_a_lo, hit_a_hi, hit_b_lo, hit_b_hi;
   logic hit_cap_lo, hit_cap_hi, hit_flg, hit_msk, hit_pow, hit_any, hit_hi16;
   assign hit_ca = paddr == t16bac_pkg::ADR_CTRL_A;
   assign hit_cb = paddr == t16bac_pkg::ADR_CTRL_B;
   assign hit_cnt_lo = paddr == t16bac_pkg::ADR_CNT_LO;
   assign hit_cnt_hi = paddr == t16bac_pkg::ADR_CNT_HI;
   assign hit_a_lo = paddr == t16bac_pkg::ADR_CMPA_LO;
   assign hit_a_hi = paddr == t16bac_pkg::ADR_CMPA_HI;
   assign hit_b_lo = paddr == t16bac_pkg::ADR_CMPB_LO;
   assign hit_b_hi = paddr == t16bac_pkg::ADR_CMPB_HI;
   assign hit_cap_lo = paddr == t16bac_pkg::ADR_CAP_LO;
   assign hit_cap_hi = paddr == t16bac_pkg::ADR_CAP_HI;
   assign hit_flg = paddr == t16bac_pkg::ADR_FLAGS;
   assign hit_msk = paddr == t16bac_pkg::ADR_MASK;
   assign hit_pow = paddr == t16bac_pkg::ADR_POWER;
   assign hit_hi16 = hit_cnt_hi | hit_a_hi | hit_b_hi | hit_cap_hi;
   assign hit_any = hit_ca | hit_cb | hit_cnt_lo | hit_a_lo | hit_b_lo | hit_cap_lo | hit_hi16
      | hit_flg | hit_msk | hit_pow;

   // write strobes; only low-byte writes reach the 16-bit registers
   logic cnt_wr, a_wr, b_wr, cap_wr, stage_wr;
   logic [15:0] commit_word;
   assign commit_word = {stage_ff, wbyte};
   assign cnt_wr = wr_do & hit_cnt_lo;
   assign a_wr = wr_do & hit_a_lo;
   assign b_wr = wr_do & hit_b_lo;
   assign cap_wr = wr_do & hit_cap_lo;
   assign stage_wr = wr_do & hit_hi16;

   // mode and limit decode
   logic [2:0] mode;
   logic pwm, top_is_a, cap_is_top, at_top;
   logic [15:0] top_val;
   assign mode = {ctrl_b_ff[t16bac_pkg::CB_MODE_HI], ctrl_a_ff[t16bac_pkg::CA_MODE_LSB +: 2]};
   assign pwm = (mode != t16bac_pkg::MODE_NORMAL) & (mode != t16bac_pkg::MODE_CTC_A)
      & (mode != t16bac_pkg::MODE_CTC_CAP);
   assign top_is_a = (mode == t16bac_pkg::MODE_CTC_A) | (mode == t16bac_pkg::MODE_PWM_A);
   assign cap_is_top = (mode == t16bac_pkg::MODE_CTC_CAP) | (mode == t16bac_pkg::MODE_PWM_CAP);
   assign top_val = top_is_a ? cmp_a_act_ff :
      cap_is_top ? capture_ff :
      (mode == t16bac_pkg::MODE_PWM_8B) ? t16bac_pkg::TOP_8B :
      (mode == t16bac_pkg::MODE_PWM_9B) ? t16bac_pkg::TOP_9B :
      (mode == t16bac_pkg::MODE_PWM_10B) ? t16bac_pkg::TOP_10B : t16bac_pkg::MAX;
   assign at_top = count_ff == top_val;

   // tick source and capture front end; both idle while powered off
   logic run, tick, cap_evt;
   assign run = ~power_off_ff;
   t16bac_tick_gen #(.PRESC_W(t16bac_pkg::PRESC_W)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .source_sel(ctrl_b_ff[t16bac_pkg::CB_CS_LSB +: 3]),
      .ext_count_pin(ext_count_pin),
      .tick(tick)
   );
   t16bac_capture_in #(.FILT_LEN(t16bac_pkg::FILTER_LEN)) u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .use_comp(ctrl_a_ff[t16bac_pkg::CA_CAP_SRC]),
      .rising(ctrl_b_ff[t16bac_pkg::CB_EDGE]),
      .filter_en(ctrl_b_ff[t16bac_pkg::CB_FILT]),
      .capture_input_pin(capture_input_pin),
      .comparator_out(comparator_out),
      .event_pulse(cap_evt)
   );

   // events; a counter write hides the match on the following tick
   logic ovf_evt, match_a_evt, match_b_evt, cap_store, buf_load;
   logic [3:0] flag_set, flag_clr;
   assign ovf_evt = tick & ((count_ff == t16bac_pkg::MAX) | (pwm & at_top));
   assign match_a_evt = tick & ~block_ff & (count_ff == cmp_a_act_ff);
   assign match_b_evt = tick & ~block_ff & (count_ff == cmp_b_act_ff);
   assign cap_store = cap_evt & ~cap_is_top; // capture is frozen while it sets top
   assign flag_set = {cap_store, match_b_evt, match_a_evt, ovf_evt};
   assign flag_clr = (wr_do & hit_flg) ? wbyte[3:0] : 4'h0;
   assign buf_load = ~pwm | (tick & at_top);

   // next counter value
   logic [15:0] nxt_count;
   assign nxt_count = cnt_wr ? commit_word :
      tick ? (at_top ? t16bac_pkg::BOTTOM : count_ff + 16'h0001) : count_ff;

   // read data; compare bytes come straight from the buffers
   logic [7:0] rd_byte;
   assign rd_byte = ({8{hit_ca}} & ctrl_a_ff) | ({8{hit_cb}} & ctrl_b_ff)
      | ({8{hit_cnt_lo}} & count_ff[7:0]) | ({8{hit_cap_lo}} & capture_ff[7:0])
      | ({8{hit_cnt_hi | hit_cap_hi}} & stage_ff)
      | ({8{hit_a_lo}} & cmp_a_buf_ff[7:0]) | ({8{hit_a_hi}} & cmp_a_buf_ff[15:8])
      | ({8{hit_b_lo}} & cmp_b_buf_ff[7:0]) | ({8{hit_b_hi}} & cmp_b_buf_ff[15:8])
      | ({8{hit_flg}} & {4'h0, flags_ff}) | ({8{hit_msk}} & {4'h0, mask_ff})
      | ({8{hit_pow}} & {7'h00, power_off_ff});

   // apb answer: one wait state, unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= acc_prep;
         pslverr_ff <= acc_prep & ~hit_any;
         prdata_ff <= rd_do ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // shared staging byte: high writes land here, low reads of counter and capture fill it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_ff <= t16bac_pkg::RST_BYTE;
      end else if (stage_wr) begin
         stage_ff <= wbyte;
      end else if (rd_do & hit_cnt_lo) begin
         stage_ff <= count_ff[15:8];
      end else if (rd_do & hit_cap_lo) begin
         stage_ff <= capture_ff[15:8];
      end
   end

   // control, mask and power registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_ff <= t16bac_pkg::RST_BYTE;
         ctrl_b_ff <= t16bac_pkg::RST_BYTE;
         mask_ff <= 4'h0;
         power_off_ff <= t16bac_pkg::RST_POWER_OFF;
      end else begin
         if (wr_do & hit_ca) ctrl_a_ff <= wbyte;
         if (wr_do & hit_cb) ctrl_b_ff <= wbyte;
         if (wr_do & hit_msk) mask_ff <= wbyte[3:0];
         if (wr_do & hit_pow) power_off_ff <= wbyte[t16bac_pkg::POW_OFF];
      end
   end

   // counter, capture and limit indications
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= t16bac_pkg::RST_WORD;
         capture_ff <= t16bac_pkg::RST_WORD;
         block_ff <= 1'b0;
         bottom_ff <= 1'b1;
         max_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         if (cap_wr) capture_ff <= commit_word;
         else if (cap_store) capture_ff <= count_ff;
         block_ff <= cnt_wr | (block_ff & ~tick);
         bottom_ff <= nxt_count == t16bac_pkg::BOTTOM;
         max_ff <= nxt_count == t16bac_pkg::MAX;
      end
   end

   // compare buffers and their active copies; pwm modes swap only at top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_a_buf_ff <= t16bac_pkg::RST_WORD;
         cmp_b_buf_ff <= t16bac_pkg::RST_WORD;
         cmp_a_act_ff <= t16bac_pkg::RST_WORD;
         cmp_b_act_ff <= t16bac_pkg::RST_WORD;
      end else begin
         if (a_wr) cmp_a_buf_ff <= commit_word;
         if (b_wr) cmp_b_buf_ff <= commit_word;
         if (buf_load) cmp_a_act_ff <= cmp_a_buf_ff;
         if (buf_load) cmp_b_act_ff <= cmp_b_buf_ff;
      end
   end

   // flags: a set in the clearing cycle wins; requests follow flags and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= 4'h0;
         irq_ff <= 4'h0;
      end else begin
         flags_ff <= (flags_ff & ~flag_clr) | flag_set;
         irq_ff <= ((flags_ff & ~flag_clr) | flag_set) & mask_ff;
      end
   end

   // toggle waveforms on match; channel A is silent while it sets pwm top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_a_ff <= 1'b0;
         wave_b_ff <= 1'b0;
      end else begin
         if (mode == t16bac_pkg::MODE_PWM_A) wave_a_ff <= 1'b0;
         else if (match_a_evt & ctrl_a_ff[t16bac_pkg::CA_TOG_A]) wave_a_ff <= ~wave_a_ff;
         if (match_b_evt & ctrl_a_ff[t16bac_pkg::CA_TOG_B]) wave_b_ff <= ~wave_b_ff;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign wave_out_a = wave_a_ff;
   assign wave_out_b = wave_b_ff;
   assign timer_irq_req = irq_ff;
   assign at_bottom = bottom_ff;
   assign at_max = max_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_lo_write_commit: assert property (cnt_wr |=> count_ff == {$past(stage_ff), $past(wbyte)})
      else $error("counter low write did not commit staged word");
   chk_lo_read_stage: assert property (rd_do && hit_cnt_lo |=> stage_ff == $past(count_ff[15:8]))
      else $error("counter low read did not fill staging byte");
   chk_cmp_read_quiet: assert property (rd_do && (hit_a_lo || hit_a_hi || hit_b_lo || hit_b_hi)
      |=> $stable(stage_ff)) else $error("compare read disturbed staging byte");
   chk_cmp_hi_direct: assert property (rd_do && hit_b_hi |=> prdata_ff[7:0] == cmp_b_buf_ff[15:8])
      else $error("compare high read not direct");
   chk_hi_write_stage: assert property (wr_do && hit_a_hi |=> stage_ff == $past(wbyte)
      && $stable(cmp_a_buf_ff)) else $error("high write reached a 16-bit register");
   chk_ctrl_rw: assert property (wr_do && hit_cb |=> ctrl_b_ff == $past(wbyte))
      else $error("control b write lost");
   chk_match_flag: assert property (match_a_evt |=> flags_ff[t16bac_pkg::FLG_A])
      else $error("match a did not set its flag");
   chk_irq_gate: assert property ($rose(flags_ff[t16bac_pkg::FLG_OVF]) |->
      irq_ff[t16bac_pkg::FLG_OVF] == $past(mask_ff[t16bac_pkg::FLG_OVF]))
      else $error("overflow request not gated by mask");
   chk_stopped: assert property ((power_off_ff
      || ctrl_b_ff[t16bac_pkg::CB_CS_LSB +: 3] == t16bac_pkg::CS_STOP)
      && !cnt_wr |=> $stable(count_ff)) else $error("counter moved without a source");
   chk_capture_store: assert property (cap_store && !cap_wr |=> capture_ff == $past(count_ff))
      else $error("capture did not store counter");
   chk_limit_flags: assert property (bottom_ff == (count_ff == t16bac_pkg::BOTTOM)
      && max_ff == (count_ff == t16bac_pkg::MAX)) else $error("limit indication wrong");
   chk_top_wrap: assert property (tick && at_top && !cnt_wr |=> count_ff == t16bac_pkg::BOTTOM)
      else $error("counter did not wrap at top");
   chk_pwm_a_quiet: assert property (mode == t16bac_pkg::MODE_PWM_A && !(tick && at_top)
      |=> !wave_a_ff && $stable(cmp_a_act_ff)) else $error("pwm top on a not held");

   cov_ovf: cover property (ovf_evt);
   cov_capture: cover property (cap_store);
   cov_word_read: cover property (rd_do && hit_cnt_lo ##[2:20] rd_do && hit_cnt_hi);
endmodule : t16bac_core

// ### src/t16bac_pkg.sv
package t16bac_pkg;
   // register byte addresses on the apb window
   localparam logic [7:0] ADR_CTRL_A = 8'h00;
   localparam logic [7:0] ADR_CTRL_B = 8'h04;
   localparam logic [7:0] ADR_CNT_LO = 8'h08;
   localparam logic [7:0] ADR_CNT_HI = 8'h0C;
   localparam logic [7:0] ADR_CMPA_LO = 8'h10;
   localparam logic [7:0] ADR_CMPA_HI = 8'h14;
   localparam logic [7:0] ADR_CMPB_LO = 8'h18;
   localparam logic [7:0] ADR_CMPB_HI = 8'h1C;
   localparam logic [7:0] ADR_CAP_LO = 8'h20;
   localparam logic [7:0] ADR_CAP_HI = 8'h24;
   localparam logic [7:0] ADR_FLAGS = 8'h28;
   localparam logic [7:0] ADR_MASK = 8'h2C;
   localparam logic [7:0] ADR_POWER = 8'h30;

   // timer_control_a fields
   localparam int CA_MODE_LSB = 0;
   localparam int CA_CAP_SRC = 2;
   localparam int CA_TOG_A = 4;
   localparam int CA_TOG_B = 5;
   // timer_control_b fields
   localparam int CB_CS_LSB = 0;
   localparam int CB_MODE_HI = 3;
   localparam int CB_EDGE = 6;
   localparam int CB_FILT = 7;
   // flag and mask bit positions
   localparam int FLG_OVF = 0;
   localparam int FLG_A = 1;
   localparam int FLG_B = 2;
   localparam int FLG_CAP = 3;
   localparam int NUM_IRQ = 4;
   localparam int POW_OFF = 0;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic RST_POWER_OFF = 1'b1;

   // limit values of the count sequence
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8B = 16'h00FF;
   localparam logic [15:0] TOP_9B = 16'h01FF;
   localparam logic [15:0] TOP_10B = 16'h03FF;

   // count sequence modes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PWM_8B = 3'h1;
   localparam logic [2:0] MODE_PWM_9B = 3'h2;
   localparam logic [2:0] MODE_PWM_10B = 3'h3;
   localparam logic [2:0] MODE_CTC_A = 3'h4;
   localparam logic [2:0] MODE_CTC_CAP = 3'h5;
   localparam logic [2:0] MODE_PWM_CAP = 3'h6;
   localparam logic [2:0] MODE_PWM_A = 3'h7;

   // tick source selections
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   localparam int PRESC_W = 10;
   localparam int FILTER_LEN = 4;
endpackage : t16bac_pkg

// ### src/t16bac_tick_gen.sv
`timescale 1ns/1ps
module t16bac_tick_gen #(
   parameter int PRESC_W = t16bac_pkg::PRESC_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] source_sel,
   input wire logic ext_count_pin,
   output logic tick
);
   logic [PRESC_W-1:0] presc_ff;
   logic ext_prev_ff;
   logic ext_rise;
   logic ext_fall;

   // free prescaler; held at zero while run is low (powered off) so the first period is whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= '0;
         ext_prev_ff <= 1'b0;
      end else begin
         presc_ff <= run ? presc_ff + 1'b1 : '0;
         ext_prev_ff <= ext_count_pin;
      end
   end

   // pin edges count even if the pin is driven by software
   assign ext_rise = ext_count_pin & ~ext_prev_ff;
   assign ext_fall = ~ext_count_pin & ext_prev_ff;

   // source and edge selection
   assign tick = run & (
      (source_sel == t16bac_pkg::CS_DIV1) |
      ((source_sel == t16bac_pkg::CS_DIV8) & (&presc_ff[2:0])) |
      ((source_sel == t16bac_pkg::CS_DIV64) & (&presc_ff[5:0])) |
      ((source_sel == t16bac_pkg::CS_DIV256) & (&presc_ff[7:0])) |
      ((source_sel == t16bac_pkg::CS_DIV1024) & (&presc_ff[9:0])) |
      ((source_sel == t16bac_pkg::CS_EXT_FALL) & ext_fall) |
      ((source_sel == t16bac_pkg::CS_EXT_RISE) & ext_rise));
endmodule : t16bac_tick_gen
